// File: rtl/ssc_serial_ctrl.sv
// two-wire serial control, status and divider load of the synthesizer
// Summary of operation
// - respond to six fixed address bits, select-pin bit, then read/write bit
// - address bit from select pin is inverted: high pin gives 0
// - write: address, subaddress, then one to four data bytes
// - serial data is gathered into bytes and stored in the addressed register
// - first byte goes to pointer register; autoinc advances for later bytes
// - without autoinc all bytes land in the same register
// - subaddress bit 4 alarm mask, bit 3 autoinc, bits 1:0 pointer
// - pointer 0 setup, 1 loop, 2 divider middle, 3 divider low
// - alarm mask set keeps alarm output released
// - lock loss or supply dip pulls alarm low and holds it
// - alarm releases only after the status register is read or the alarm mask is set
// - status: bit4 now, bit2 lock latched, bit1 dip latched, bit0 mask
// - status read is address with read bit and exactly one byte
// - setup: bit7 sleep, bit5 pump current, bits 3:0 reference ratio
// - pump current select 1 means 1 mA, 0 means 0.5 mA
// - reference code maps to ratios 128 through 1920
// - loop: bits 7:5 fixed 101, polarity, switches, top ratio bits
// - detector polarity swaps up and down; equal frequency drives neither
// - 18-bit ratio: upper 13 to main counter, low 5 to swallow
// - new ratio reaches counters after low byte, synced to divider clock
// - ratio below 2048 is used plus 2048
// - lock loss flags at once, clears after 6 good reference cycles
// - serial transfers and registers keep working during sleep
`timescale 1ns/100ps
`default_nettype none
module ssc_serial_ctrl (
	// system
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// divider output clock
	input wire logic div_clk,
	// serial bus
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_select_pin,
	// detector and supply monitor pins
	input wire logic phase_err_high,
	input wire logic ref_tick_pin,
	input wire logic ref_faster,
	input wire logic ref_slower,
	input wire logic supply_dip,
	// alarm, open collector
	output logic alarm_out,
	output logic alarm_oe,
	// setup outputs
	output logic sleep_ctrl,
	output logic pump_current_sel,
	output logic [10:0] ref_div_ratio,
	output logic switch_out_a,
	output logic switch_out_b,
	output logic pump_up,
	output logic pump_down,
	// counter chain, div_clk domain
	output logic [12:0] main_count,
	output logic [4:0] swallow_count
);
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_SUB, S_SUB_ACK,
		S_WDATA, S_WDATA_ACK, S_RDATA, S_RD_ACK
	} ssc_state_t;

	ssc_state_t state;
	logic [7:0] regs [4];
	logic [7:0] shift;
	logic [3:0] bit_cnt;
	logic [2:0] nbytes;
	logic [1:0] ptr;
	logic autoinc, alarm_mask, rw;
	logic [6:0] sync_m, sync_s;
	logic scl_prev, sda_prev, ref_prev;
	logic lock_now, lock_lat, dip_lat;
	logic [2:0] good_cnt;
	logic [17:0] ratio_hold;
	logic ratio_tgl;
	logic div_rst_m, div_rst_s, tgl_m, tgl_s, tgl_prev;
	logic [7:0] status_byte;

	// synchronised pins
	wire scl_s = sync_s[0];
	wire sda_s = sync_s[1];
	wire saa_s = sync_s[2];
	wire err_s = sync_s[3];
	wire ref_s = sync_s[4];
	wire fast_s = sync_s[5];
	wire slow_s = sync_s[6];
	wire dip_s;
	logic dip_m, dip_q;
	wire slow_in_w = ref_slower;
	wire fast_in_w = ref_faster;
	wire switch_pol = regs[ssc_pkg::REG_LOOP][ssc_pkg::LOOP_POL_BIT];
	assign dip_s = dip_q;

	// bus events
	wire scl_rise = scl_s & ~scl_prev;
	wire scl_fall = ~scl_s & scl_prev;
	wire bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
	wire bus_stop = scl_s & scl_prev & ~sda_prev & sda_s;
	wire byte_done = scl_fall && (bit_cnt == ssc_pkg::BYTE_BITS);
	wire addr_match = (shift[7:1] == {ssc_pkg::ADDR_FIXED, ~saa_s});
	wire addr_ok = (state == S_ADDR) && byte_done && addr_match;
	wire sub_done = (state == S_SUB) && byte_done;
	wire room = (nbytes < ssc_pkg::MAX_DATA_BYTES);
	wire wr_en = (state == S_WDATA) && byte_done && room;
	wire rd_done = (state == S_RD_ACK) && scl_rise;
	wire ref_tick = ref_s & ~ref_prev;
	wire lock_event = lock_now | dip_s;

	always_comb begin
		status_byte = 8'h00;
		status_byte[ssc_pkg::ST_NOW_BIT] = lock_now;
		status_byte[ssc_pkg::ST_LOCK_BIT] = lock_lat;
		status_byte[ssc_pkg::ST_DIP_BIT] = dip_lat;
		status_byte[ssc_pkg::ST_MASK_BIT] = alarm_mask;
	end

	// two-stage synchronisers; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// idle pin levels, else false bus edges follow reset
			sync_m <= 7'h07;
			sync_s <= 7'h07;
			dip_m <= 1'b0;
			dip_q <= 1'b0;
		end else if (ce) begin
			sync_m <= {slow_in_w, fast_in_w, ref_tick_pin, phase_err_high,
				addr_select_pin, sda_in, scl};
			sync_s <= sync_m;
			dip_m <= supply_dip;
			dip_q <= dip_m;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			ref_prev <= 1'b1;
		end else if (ce) begin
			scl_prev <= scl_s;
			sda_prev <= sda_s;
			ref_prev <= ref_s;
		end
	end

	// serial slave; start and stop win over any bit activity
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= S_IDLE;
			shift <= 8'h00;
			bit_cnt <= 4'h0;
			nbytes <= 3'h0;
			rw <= 1'b0;
			sda_oe <= 1'b0;
		end else if (ce) begin
			if (bus_start) begin
				state <= S_ADDR;
				bit_cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				state <= S_IDLE;
				sda_oe <= 1'b0;
			end else begin
				unique case (state)
					S_IDLE: begin
					end
					S_ADDR, S_SUB, S_WDATA: begin
						if (scl_rise) begin
							shift <= {shift[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (byte_done) begin
							bit_cnt <= 4'h0;
							if (addr_ok) begin
								rw <= shift[0];
								sda_oe <= 1'b1;
								state <= S_ADDR_ACK;
							end else if (sub_done) begin
								sda_oe <= 1'b1;
								nbytes <= 3'h0;
								state <= S_SUB_ACK;
							end else if (wr_en) begin
								sda_oe <= 1'b1;
								nbytes <= nbytes + 3'h1;
								state <= S_WDATA_ACK;
							end else begin
								state <= S_IDLE;
							end
						end
					end
					S_ADDR_ACK: begin
						if (scl_fall && rw) begin
							shift <= {status_byte[6:0], 1'b0};
							sda_oe <= ~status_byte[7];
							bit_cnt <= 4'h1;
							state <= S_RDATA;
						end else if (scl_fall) begin
							sda_oe <= 1'b0;
							state <= S_SUB;
						end
					end
					S_SUB_ACK, S_WDATA_ACK: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							state <= S_WDATA;
						end
					end
					S_RDATA: begin
						if (byte_done) begin
							sda_oe <= 1'b0;
							state <= S_RD_ACK;
						end else if (scl_fall) begin
							sda_oe <= ~shift[7];
							shift <= {shift[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
					S_RD_ACK: begin
						if (scl_rise) begin
							state <= S_IDLE;
						end
					end
				endcase
			end
		end
	end

	// subaddress flags and pointer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ptr <= ssc_pkg::REG_SETUP;
			autoinc <= 1'b0;
			alarm_mask <= 1'b0;
		end else if (ce) begin
			if (sub_done) begin
				alarm_mask <= shift[ssc_pkg::SUB_MASK_BIT];
				autoinc <= shift[ssc_pkg::SUB_AUTOINC_BIT];
				ptr <= shift[1:0];
			end else if (wr_en && autoinc) begin
				ptr <= ptr + 2'h1;
			end
		end
	end

	// register file; stays live while sleeping
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regs[ssc_pkg::REG_SETUP] <= ssc_pkg::SETUP_RST;
			regs[ssc_pkg::REG_LOOP] <= ssc_pkg::LOOP_RST;
			regs[ssc_pkg::REG_DIV_MID] <= ssc_pkg::DIV_MID_RST;
			regs[ssc_pkg::REG_DIV_LOW] <= ssc_pkg::DIV_LOW_RST;
		end else if (ce && wr_en) begin
			if (ptr == ssc_pkg::REG_LOOP) begin
				regs[ptr] <= {ssc_pkg::LOOP_FIXED, shift[4:0]};
			end else begin
				regs[ptr] <= shift;
			end
		end
	end

	// 18-bit latch, handed over only when the low byte lands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ratio_hold <= {ssc_pkg::LOOP_RST[1:0], ssc_pkg::DIV_MID_RST,
				ssc_pkg::DIV_LOW_RST};
			ratio_tgl <= 1'b0;
		end else if (ce && wr_en && ptr == ssc_pkg::REG_DIV_LOW) begin
			ratio_hold <= {regs[ssc_pkg::REG_LOOP][1:0],
				regs[ssc_pkg::REG_DIV_MID], shift};
			ratio_tgl <= ~ratio_tgl;
		end
	end

	// setup outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_div_ratio <= ssc_pkg::ref_ratio(ssc_pkg::SETUP_RST[3:0]);
			pump_up <= 1'b0;
			pump_down <= 1'b0;
		end else if (ce) begin
			ref_div_ratio <= ssc_pkg::ref_ratio(regs[0][3:0]);
			// pump held off while asleep; equal frequency drives neither
			pump_up <= ~sleep_ctrl & (switch_pol ? slow_s : fast_s) &
				~(fast_s & slow_s);
			pump_down <= ~sleep_ctrl & (switch_pol ? fast_s : slow_s) &
				~(fast_s & slow_s);
		end
	end
	assign sleep_ctrl = regs[ssc_pkg::REG_SETUP][ssc_pkg::SETUP_SLEEP_BIT];
	assign pump_current_sel =
		regs[ssc_pkg::REG_SETUP][ssc_pkg::SETUP_PUMP_BIT];
	assign switch_out_a = regs[ssc_pkg::REG_LOOP][ssc_pkg::LOOP_SWA_BIT];
	assign switch_out_b = regs[ssc_pkg::REG_LOOP][ssc_pkg::LOOP_SWB_BIT];

	// lock monitor
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lock_now <= 1'b0;
			good_cnt <= 3'h0;
		end else if (ce) begin
			if (err_s) begin
				lock_now <= 1'b1;
				good_cnt <= 3'h0;
			end else if (ref_tick && lock_now) begin
				if (good_cnt == ssc_pkg::LOCK_GOOD_CYCLES - 3'h1) begin
					lock_now <= 1'b0;
					good_cnt <= 3'h0;
				end else begin
					good_cnt <= good_cnt + 3'h1;
				end
			end
		end
	end

	// latched flags and alarm; a new event beats the read clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lock_lat <= 1'b0;
			dip_lat <= 1'b0;
			alarm_oe <= 1'b0;
			alarm_out <= 1'b0;
		end else if (ce) begin
			lock_lat <= lock_now | (lock_lat & ~rd_done);
			dip_lat <= dip_s | (dip_lat & ~rd_done);
			alarm_oe <= ~alarm_mask &
				(lock_event | (alarm_oe & ~rd_done));
		end
	end
	assign sda_out = 1'b0;

	// divider domain: reset sync, toggle sync, counter load
	always_ff @(posedge div_clk) begin
		div_rst_m <= rst_n;
		div_rst_s <= div_rst_m;
	end

	always_ff @(posedge div_clk) begin
		if (!div_rst_s) begin
			tgl_m <= 1'b0;
			tgl_s <= 1'b0;
			tgl_prev <= 1'b0;
			{main_count, swallow_count} <= ssc_pkg::ratio_eff(
				{ssc_pkg::LOOP_RST[1:0], ssc_pkg::DIV_MID_RST,
				ssc_pkg::DIV_LOW_RST});
		end else begin
			tgl_m <= ratio_tgl;
			tgl_s <= tgl_m;
			tgl_prev <= tgl_s;
			if (tgl_s ^ tgl_prev) begin
				{main_count, swallow_count} <=
					ssc_pkg::ratio_eff(ratio_hold);
			end
		end
	end

	a_addr_ack: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && state == S_ADDR && byte_done &&
		shift[7:1] == {ssc_pkg::ADDR_FIXED, ~saa_s})
		|=> (state == S_ADDR_ACK && sda_oe))
		else $error("own address not acknowledged");
	a_addr_nack: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && state == S_ADDR && byte_done && !addr_match)
		|=> (state == S_IDLE && !sda_oe))
		else $error("foreign address acknowledged");
	a_sub_decode: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && sub_done) |=> (alarm_mask == $past(shift[4]) &&
		autoinc == $past(shift[3]) && ptr == $past(shift[1:0])))
		else $error("subaddress decode wrong");
	a_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && wr_en && autoinc) |=> (ptr == $past(ptr) + 2'h1))
		else $error("pointer did not advance");
	a_ptr_fixed: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && wr_en && !autoinc) |=> (ptr == $past(ptr)))
		else $error("pointer moved without autoinc");
	a_byte_limit: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && state == S_WDATA && byte_done && !room)
		|=> (state == S_IDLE && !sda_oe))
		else $error("fifth data byte accepted");
	a_mask_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && alarm_mask) |=> !alarm_oe)
		else $error("alarm driven while masked");
	a_alarm_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && alarm_oe && !rd_done && !alarm_mask) |=> alarm_oe)
		else $error("alarm released without read");
	a_alarm_free: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && rd_done && !lock_now && !dip_s) |=> !alarm_oe)
		else $error("alarm kept after status read");
	a_lock_clear: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(lock_now) |-> ($past(good_cnt) == 3'h5 && !$past(err_s)))
		else $error("lock flag cleared early");
	a_pump_dir: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !sleep_ctrl && fast_s && !slow_s && !switch_pol)
		|=> (pump_up && !pump_down))
		else $error("pump direction wrong");
	a_ratio_floor: assert property (@(posedge div_clk)
		disable iff (!div_rst_s)
		{main_count, swallow_count} >= ssc_pkg::RATIO_FLOOR)
		else $error("ratio below floor");
endmodule : ssc_serial_ctrl
`default_nettype wire

// File: rtl/ssc_pkg.sv
// constants and helpers for the synthesizer serial control block
package ssc_pkg;
	// register pointer codes
	localparam logic [1:0] REG_SETUP = 2'h0;
	localparam logic [1:0] REG_LOOP = 2'h1;
	localparam logic [1:0] REG_DIV_MID = 2'h2;
	localparam logic [1:0] REG_DIV_LOW = 2'h3;
	// presets
	localparam logic [7:0] SETUP_RST = 8'h0e;
	localparam logic [7:0] LOOP_RST = 8'ha5;
	localparam logic [7:0] DIV_MID_RST = 8'h38;
	localparam logic [7:0] DIV_LOW_RST = 8'h80;
	// subaddress fields
	localparam int SUB_MASK_BIT = 4;
	localparam int SUB_AUTOINC_BIT = 3;
	// setup register fields
	localparam int SETUP_SLEEP_BIT = 7;
	localparam int SETUP_PUMP_BIT = 5;
	// loop register fields
	localparam int LOOP_POL_BIT = 4;
	localparam int LOOP_SWB_BIT = 3;
	localparam int LOOP_SWA_BIT = 2;
	localparam logic [2:0] LOOP_FIXED = 3'h5;
	// status byte fields
	localparam int ST_NOW_BIT = 4;
	localparam int ST_LOCK_BIT = 2;
	localparam int ST_DIP_BIT = 1;
	localparam int ST_MASK_BIT = 0;
	// fixed upper address bits; value is arbitrary
	localparam logic [5:0] ADDR_FIXED = 6'h2d;
	localparam logic [2:0] MAX_DATA_BYTES = 3'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] LOCK_GOOD_CYCLES = 3'h6;
	localparam int SWALLOW_W = 5;
	localparam logic [17:0] RATIO_FLOOR = 18'h0_0800;

	function automatic logic [10:0] ref_ratio(input logic [3:0] code);
		unique case (code)
			4'h0: ref_ratio = 11'h080;
			4'h1: ref_ratio = 11'h0a0;
			4'h2: ref_ratio = 11'h0c0;
			4'h3: ref_ratio = 11'h0f0;
			4'h4: ref_ratio = 11'h100;
			4'h5: ref_ratio = 11'h140;
			4'h6: ref_ratio = 11'h180;
			4'h7: ref_ratio = 11'h1e0;
			4'h8: ref_ratio = 11'h200;
			4'h9: ref_ratio = 11'h280;
			4'ha: ref_ratio = 11'h300;
			4'hb: ref_ratio = 11'h3c0;
			4'hc: ref_ratio = 11'h400;
			4'hd: ref_ratio = 11'h500;
			4'he: ref_ratio = 11'h600;
			4'hf: ref_ratio = 11'h780;
		endcase
	endfunction : ref_ratio

	// ratios under the floor are lifted by the floor
	function automatic logic [17:0] ratio_eff(input logic [17:0] r);
		ratio_eff = (r < RATIO_FLOOR) ? 18'(r + RATIO_FLOOR) : r;
	endfunction : ratio_eff
endpackage : ssc_pkg

// File: testbench/ssc_bus_master.sv
// two-wire bus master model, stepping on the system clock
`timescale 1ns/100ps
`default_nettype none
module ssc_bus_master (
	// system
	input wire logic clk,
	// serial bus
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	// quarter bit of 2.5 us keeps the bus at 100 kHz
	localparam int QTR = 250;

	initial begin
		scl = 1'b1;
		sda_drv = 1'b0;
	end

	task automatic q(input logic c, input logic d);
		repeat (QTR) @(posedge clk);
		scl <= c;
		sda_drv <= d;
	endtask : q

	task automatic start();
		q(1'b1, 1'b1);
		q(1'b0, 1'b1);
	endtask : start

	// data pulled low while the clock is low, then released with the clock high
	task automatic stop();
		q(1'b0, 1'b1);
		q(1'b1, 1'b1);
		q(1'b1, 1'b0);
	endtask : stop

	// msb first; ack sampled mid high phase of the ninth clock
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			q(1'b0, ~b[i]);
			q(1'b1, ~b[i]);
			q(1'b1, ~b[i]);
			q(1'b0, ~b[i]);
		end
		q(1'b0, 1'b0);
		q(1'b1, 1'b0);
		q(1'b1, 1'b0);
		ack = (sda === 1'b0);
		q(1'b0, 1'b0);
	endtask : put_byte

	// single byte then no acknowledge from the master
	task automatic get_byte(output logic [7:0] d);
		for (int i = 8; i >= 0; i--) begin
			q(1'b0, 1'b0);
			q(1'b1, 1'b0);
			q(1'b1, 1'b0);
			if (i > 0)
				d[i - 1] = sda;
			q(1'b0, 1'b0);
		end
	endtask : get_byte
endmodule : ssc_bus_master
`default_nettype wire

// File: testbench/ssc_serial_ctrl_tb_top.sv
// self-checking bench for the synthesizer serial control block
`timescale 1ns/100ps
`default_nettype none
module ssc_serial_ctrl_tb_top;
	localparam int LIMIT = 95000;
	logic clk, rst_n, div_clk, addr_select_pin, phase_err_high;
	logic ref_tick_pin, ref_faster, ref_slower, supply_dip;
	logic scl, m_drv, sda_out, sda_oe, alarm_out, alarm_oe, sleep_ctrl;
	logic pump_current_sel, switch_out_a, switch_out_b, pump_up, pump_down;
	logic [10:0] ref_div_ratio;
	logic [12:0] main_count;
	logic [4:0] swallow_count;
	logic ack;
	logic [7:0] st;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	// pull-up: low while either party pulls
	wire sda = ~(m_drv | sda_oe);

	ssc_serial_ctrl dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.div_clk(div_clk), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_select_pin(addr_select_pin),
		.phase_err_high(phase_err_high), .ref_tick_pin(ref_tick_pin),
		.ref_faster(ref_faster), .ref_slower(ref_slower),
		.supply_dip(supply_dip), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
		.sleep_ctrl(sleep_ctrl), .pump_current_sel(pump_current_sel),
		.ref_div_ratio(ref_div_ratio), .switch_out_a(switch_out_a),
		.switch_out_b(switch_out_b), .pump_up(pump_up),
		.pump_down(pump_down), .main_count(main_count),
		.swallow_count(swallow_count));
	ssc_bus_master master (.clk(clk), .sda(sda), .scl(scl), .sda_drv(m_drv));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// divider clock, phase unrelated to the system clock
	initial begin
		div_clk = 1'b0;
		#17;
		forever #32 div_clk = ~div_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			conclude();
		end
	end

	task automatic check(input string name, input logic [17:0] exp,
		input logic [17:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic pumps(input logic f, input logic s, input logic eu,
		input logic ed);
		@(posedge clk);
		ref_faster <= f;
		ref_slower <= s;
		repeat (8) @(posedge clk);
		check("pump_up", eu, pump_up);
		check("pump_down", ed, pump_down);
	endtask : pumps

	// which: 0 phase error, 1 supply dip, else reference tick
	task automatic pulse(input int which, input int n);
		@(posedge clk);
		case (which)
			0: phase_err_high <= 1'b1;
			1: supply_dip <= 1'b1;
			default: ref_tick_pin <= 1'b1;
		endcase
		repeat (n) @(posedge clk);
		phase_err_high <= 1'b0;
		supply_dip <= 1'b0;
		ref_tick_pin <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : pulse

	initial begin
		rst_n = 1'b0;
		addr_select_pin = 1'b1;
		phase_err_high = 1'b0;
		ref_tick_pin = 1'b0;
		ref_faster = 1'b0;
		ref_slower = 1'b0;
		supply_dip = 1'b0;
		// long enough for the divider domain to see reset too
		repeat (24) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("sleep_ctrl", 1'b0, sleep_ctrl);
		check("pump_current_sel", 1'b0, pump_current_sel);
		check("ref_div_ratio", 11'h600, ref_div_ratio);
		check("switch_out_a", 1'b1, switch_out_a);
		check("switch_out_b", 1'b0, switch_out_b);
		check("main_count", 13'h09c4, main_count);
		check("swallow_count", 5'h00, swallow_count);
		check("alarm_oe", 1'b0, alarm_oe);
		pumps(1'b1, 1'b0, 1'b1, 1'b0);
		pumps(1'b0, 1'b1, 1'b0, 1'b1);
		pumps(1'b1, 1'b1, 1'b0, 1'b0);
		$display("test reset and pumps done");
		// select pin high gives address bit 0, so this one is foreign
		master.start();
		master.put_byte(8'hb6, ack);
		master.stop();
		check("foreign ack", 1'b0, ack);
		$display("test foreign address done");
		// autoinc from the loop register wraps round to setup
		master.start();
		master.put_byte(8'hb4, ack);
		check("address ack", 1'b1, ack);
		master.put_byte(8'h09, ack);
		check("subaddress ack", 1'b1, ack);
		master.put_byte(8'h18, ack);
		check("loop ack", 1'b1, ack);
		master.put_byte(8'h01, ack);
		check("middle ack", 1'b1, ack);
		master.put_byte(8'h23, ack);
		check("low ack", 1'b1, ack);
		master.put_byte(8'h2f, ack);
		check("setup ack", 1'b1, ack);
		master.stop();
		repeat (100) @(posedge clk);
		check("switch_out_a", 1'b0, switch_out_a);
		check("switch_out_b", 1'b1, switch_out_b);
		check("sleep_ctrl", 1'b0, sleep_ctrl);
		check("pump_current_sel", 1'b1, pump_current_sel);
		check("ref_div_ratio", 11'h780, ref_div_ratio);
		// ratio 291 lifted by 2048 to 2339
		check("main_count", 13'h0049, main_count);
		check("swallow_count", 5'h03, swallow_count);
		pumps(1'b1, 1'b0, 1'b0, 1'b1);
		pumps(1'b0, 1'b1, 1'b1, 1'b0);
		pumps(1'b0, 1'b0, 1'b0, 1'b0);
		$display("test write burst done");
		pulse(0, 10);
		check("alarm_oe lock", 1'b1, alarm_oe);
		pulse(1, 10);
		repeat (6) pulse(2, 5);
		check("alarm_oe held", 1'b1, alarm_oe);
		master.start();
		master.put_byte(8'hb5, ack);
		check("read ack", 1'b1, ack);
		master.get_byte(st);
		master.stop();
		check("status", 8'h06, st);
		check("alarm_oe released", 1'b0, alarm_oe);
		$display("test alarm and status done");
		conclude();
	end
endmodule : ssc_serial_ctrl_tb_top
`default_nettype wire
